// *** hdl/port9_function_select.sv ***
// Pin-function multiplexer for the sixteen port-9 lines with its APB registers.
`timescale 1ns/100ps
`default_nettype none
module port9_function_select
  import port9_mux_pkg::*;
#(
  parameter bit BUS_CAPABLE = 1'b1
)
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [APB_W-1:0] paddr,
  input wire logic [APB_W-1:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic pready,
  output logic [APB_W-1:0] prdata,
  output logic pslverr,
  input wire logic [LINES-1:0] pin_in,
  output logic [LINES-1:0] pin_out,
  output logic [LINES-1:0] pin_oe,
  input wire logic csi_ch_clock_out,
  input wire logic csi_ch_clock_oe,
  input wire logic csi_chip_select0,
  input wire logic csi_chip_select1,
  input wire logic csi_chip_select2,
  input wire logic csi_chip_select3,
  input wire logic uart1_transmit,
  input wire logic timer_q1_out0,
  input wire logic timer_q1_out1,
  input wire logic timer_q1_out2,
  input wire logic timer_q1_out3,
  input wire logic timer_p1_out0,
  input wire logic timer_p1_out1,
  input wire logic timer_p2_out0,
  input wire logic timer_p2_out1,
  input wire logic prog_clock_out,
  input wire logic serial2_data_out,
  input wire logic serial2_clock_out,
  input wire logic serial2_clock_oe,
  input wire logic addr_data_bit14_out,
  input wire logic addr_data_bit15_out,
  input wire logic addr_data_oe,
  output logic [FIN_W-1:0] func_in
);

  logic [LINES-1:0] pin_meta;
  logic [LINES-1:0] pin_sync;
  logic [LINES-1:0] port_latch;
  logic [LINES-1:0] direction_reg;
  logic [LINES-1:0] mode_control_reg;
  logic [LINES-1:0] function_select_low;
  logic [LINES-1:0] function_select_high;
  logic [LINES-1:0] next_pin_out;
  logic [LINES-1:0] next_pin_oe;
  logic [FIN_W-1:0] next_func_in;

  // Byte-lane merge; a single-bit update is a byte write of a read value.
  function automatic logic [LINES-1:0] merge_lanes(input logic [LINES-1:0] old,
                                                   input logic [LINES-1:0] wdata,
                                                   input logic [1:0] strb);
    merge_lanes = old;
    if (strb[0])
      merge_lanes[7:0] = wdata[7:0];
    if (strb[1])
      merge_lanes[15:8] = wdata[15:8];
  endfunction

  function automatic logic [1:0] pair_of(input logic [LINES-1:0] hi,
                                         input logic [LINES-1:0] lo,
                                         input int n);
    pair_of = {hi[n], lo[n]};
  endfunction

  wire access = psel && penable;
  wire done = access && pready;
  wire hit_data = (paddr == PORT_DATA_ADDR);
  wire hit_dir = (paddr == DIRECTION_ADDR);
  wire hit_mode = (paddr == MODE_CTRL_ADDR);
  wire hit_flow = (paddr == FSEL_LOW_ADDR);
  wire hit_fhigh = (paddr == FSEL_HIGH_ADDR);
  wire hit_any = hit_data || hit_dir || hit_mode || hit_flow || hit_fhigh;
  wire do_write = done && pwrite && hit_any;
  wire [1:0] lanes = pstrb[1:0];
  wire [LINES-1:0] wdata = pwdata[LINES-1:0];
  // Input lines and peripheral lines read the pin; port outputs read the latch.
  wire [LINES-1:0] data_view = ((direction_reg | mode_control_reg) & pin_sync) |
                               (~(direction_reg | mode_control_reg) & port_latch);
  wire [LINES-1:0] rd_sel = hit_data ? data_view :
                            hit_dir ? direction_reg :
                            hit_mode ? mode_control_reg :
                            hit_flow ? function_select_low :
                            hit_fhigh ? function_select_high : '0;
  wire [1:0] s0 = pair_of(function_select_high, function_select_low, 0);
  wire [1:0] s1 = pair_of(function_select_high, function_select_low, 1);
  wire [1:0] s2 = pair_of(function_select_high, function_select_low, 2);
  wire [1:0] s3 = pair_of(function_select_high, function_select_low, 3);
  wire [1:0] s12 = pair_of(function_select_high, function_select_low, 12);
  wire [1:0] s13 = pair_of(function_select_high, function_select_low, 13);
  wire [1:0] s14 = pair_of(function_select_high, function_select_low, 14);
  wire [1:0] s15 = pair_of(function_select_high, function_select_low, 15);

  // Pins are asynchronous to pclk; only the second stage is read.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pin_meta <= '0;
      pin_sync <= '0;
    end
    else
    begin
      pin_meta <= pin_in;
      pin_sync <= pin_meta;
    end
  end

  // One wait state: pready rises in the second access cycle, together with data.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready <= 1'b0;
      prdata <= '0;
      pslverr <= 1'b0;
    end
    else
    begin
      pready <= access && !pready;
      if (access && !pready)
      begin
        prdata <= {{(APB_W-LINES){1'b0}}, rd_sel};
        pslverr <= !hit_any;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      port_latch <= PORT_DATA_RESET;
      direction_reg <= DIRECTION_RESET;
      mode_control_reg <= MODE_CTRL_RESET;
      function_select_low <= FSEL_RESET;
      function_select_high <= FSEL_RESET;
    end
    else if (do_write)
    begin
      if (hit_data)
        port_latch <= merge_lanes(port_latch, wdata, lanes);
      if (hit_dir)
        direction_reg <= merge_lanes(direction_reg, wdata, lanes);
      if (hit_mode)
        mode_control_reg <= merge_lanes(mode_control_reg, wdata, lanes);
      if (hit_flow)
        function_select_low <= merge_lanes(function_select_low, wdata, lanes);
      if (hit_fhigh)
        function_select_high <= merge_lanes(function_select_high, wdata, lanes);
    end
  end

  // Lines 10 and 11 have no alternate here; setting their mode bit only releases them.
  always_comb
  begin
    next_pin_out = port_latch;
    next_pin_oe = ~direction_reg & ~mode_control_reg;
    next_func_in = FIN_IDLE;
    if (mode_control_reg[0])
      case (s0)
        SEL_00:
        begin
          next_pin_out[0] = csi_ch_clock_out;
          next_pin_oe[0] = csi_ch_clock_oe;
          next_func_in[FIN_CSI_CLK] = pin_sync[0];
        end
        SEL_01: {next_pin_out[0], next_pin_oe[0]} = {timer_q1_out1, 1'b1};
        SEL_10: next_func_in[FIN_Q1_IN1] = pin_sync[0];
        default: next_pin_oe[0] = 1'b0;
      endcase
    if (mode_control_reg[1])
      case (s1)
        SEL_00: {next_pin_out[1], next_pin_oe[1]} = {csi_chip_select0, 1'b1};
        SEL_01: {next_pin_out[1], next_pin_oe[1]} = {timer_q1_out2, 1'b1};
        SEL_10: next_func_in[FIN_Q1_IN2] = pin_sync[1];
        default: next_pin_oe[1] = 1'b0;
      endcase
    if (mode_control_reg[2])
      case (s2)
        SEL_00: {next_pin_out[2], next_pin_oe[2]} = {csi_chip_select1, 1'b1};
        SEL_01: {next_pin_out[2], next_pin_oe[2]} = {timer_q1_out3, 1'b1};
        SEL_10: next_func_in[FIN_Q1_IN3] = pin_sync[2];
        default: next_pin_oe[2] = 1'b0;
      endcase
    if (mode_control_reg[3])
      case (s3)
        SEL_00: {next_pin_out[3], next_pin_oe[3]} = {csi_chip_select2, 1'b1};
        SEL_01: {next_pin_out[3], next_pin_oe[3]} = {timer_q1_out0, 1'b1};
        SEL_10: next_func_in[FIN_Q1_IN0] = pin_sync[3];
        default: next_pin_oe[3] = 1'b0;
      endcase
    if (mode_control_reg[4])
      if (function_select_low[4])
        {next_func_in[FIN_UART_BAUD], next_pin_oe[4]} = {pin_sync[4], 1'b0};
      else
        {next_pin_out[4], next_pin_oe[4]} = {csi_chip_select3, 1'b1};
    if (mode_control_reg[5])
    begin
      next_func_in[FIN_UART_RX] = pin_sync[5];
      next_pin_oe[5] = 1'b0;
      // Line 0 owns the serial clock when both lines offer it.
      if (!function_select_low[5] && !(mode_control_reg[0] && s0 == SEL_00))
      begin
        next_pin_out[5] = csi_ch_clock_out;
        next_pin_oe[5] = csi_ch_clock_oe;
        next_func_in[FIN_CSI_CLK] = pin_sync[5];
      end
    end
    if (mode_control_reg[6])
    begin
      // Both idle high, so the AND lets either one pull the shared pin low.
      next_pin_out[6] = function_select_low[6] ? uart1_transmit :
                        (uart1_transmit & csi_chip_select0);
      next_pin_oe[6] = 1'b1;
    end
    if (mode_control_reg[7])
    begin
      next_pin_oe[7] = 1'b0;
      if (function_select_low[7])
        next_func_in[FIN_DBG_DATA] = pin_sync[7];
      else
        next_func_in[FIN_S2_DIN] = pin_sync[7];
    end
    if (mode_control_reg[8])
      if (function_select_low[8])
        {next_func_in[FIN_DBG_CLK], next_pin_oe[8]} = {pin_sync[8], 1'b0};
      else
        {next_pin_out[8], next_pin_oe[8]} = {serial2_data_out, 1'b1};
    if (mode_control_reg[9])
    begin
      if (function_select_low[9])
        {next_func_in[FIN_DBG_MODE], next_pin_oe[9]} = {pin_sync[9], 1'b0};
      else
      begin
        next_pin_out[9] = serial2_clock_out;
        next_pin_oe[9] = serial2_clock_oe;
        next_func_in[FIN_S2_CLK] = pin_sync[9];
      end
    end
    if (mode_control_reg[12])
      case (s12)
        SEL_00: {next_pin_out[12], next_pin_oe[12]} = {csi_chip_select2, 1'b1};
        SEL_01: {next_pin_out[12], next_pin_oe[12]} = {timer_p2_out1, 1'b1};
        SEL_10: next_func_in[FIN_P2_IN1] = pin_sync[12];
        default: next_pin_oe[12] = 1'b0;
      endcase
    if (mode_control_reg[13])
      case (s13)
        SEL_00: next_func_in[FIN_IRQ4] = pin_sync[13];
        SEL_01: {next_pin_out[13], next_pin_oe[13]} = {timer_p2_out0, 1'b1};
        SEL_10: next_func_in[FIN_P2_IN0] = pin_sync[13];
        default: {next_pin_out[13], next_pin_oe[13]} = {prog_clock_out, 1'b1};
      endcase
    if (mode_control_reg[14])
      case (s14)
        SEL_00: next_func_in[FIN_IRQ5] = pin_sync[14];
        SEL_01: {next_pin_out[14], next_pin_oe[14]} = {timer_p1_out0, 1'b1};
        SEL_10: next_func_in[FIN_P1_IN0] = pin_sync[14];
        default:
        begin
          next_pin_out[14] = addr_data_bit14_out;
          next_pin_oe[14] = BUS_CAPABLE && addr_data_oe;
          if (BUS_CAPABLE)
            next_func_in[FIN_ADDR_DATA_BIT14] = pin_sync[14];
        end
      endcase
    if (mode_control_reg[15])
      case (s15)
        SEL_00: next_func_in[FIN_IRQ6] = pin_sync[15];
        SEL_01: {next_pin_out[15], next_pin_oe[15]} = {timer_p1_out1, 1'b1};
        SEL_10: next_func_in[FIN_P1_IN1] = pin_sync[15];
        default:
        begin
          next_pin_out[15] = addr_data_bit15_out;
          next_pin_oe[15] = BUS_CAPABLE && addr_data_oe;
          if (BUS_CAPABLE)
            next_func_in[FIN_ADDR_DATA_BIT15] = pin_sync[15];
        end
      endcase
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pin_out <= PORT_DATA_RESET;
      pin_oe <= '0;
      func_in <= FIN_IDLE;
    end
    else
    begin
      pin_out <= next_pin_out;
      pin_oe <= next_pin_oe;
      func_in <= next_func_in;
    end
  end

  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  sequence word_write_low;
    done && pwrite && hit_flow && lanes == 2'b11;
  endsequence
  sequence high_byte_write_high;
    done && pwrite && hit_fhigh && lanes == 2'b10;
  endsequence

  AST_PORT_LINES: assert property (
    1'b1 |=> (pin_oe & ~$past(mode_control_reg)) ==
             (~$past(direction_reg) & ~$past(mode_control_reg)))
    else $error("port-mode line enable does not follow direction");
  AST_LINE4_BAUD: assert property (
    mode_control_reg[4] && function_select_low[4]
    |=> func_in[FIN_UART_BAUD] == $past(pin_sync[4]) && !pin_oe[4])
    else $error("line 4 baud clock not routed");
  AST_FSEL_WORD: assert property (
    word_write_low |=> function_select_low == $past(wdata))
    else $error("low function-select word write lost");
  AST_FSEL_HIGH_BYTE: assert property (
    high_byte_write_high |=> function_select_high[7:0] == $past(function_select_high[7:0])
      && function_select_high[15:8] == $past(wdata[15:8]))
    else $error("high function-select byte write wrong");
  AST_LINE15_IRQ: assert property (
    mode_control_reg[15] && s15 == SEL_00 |=> func_in[FIN_IRQ6] == $past(pin_sync[15]))
    else $error("line 15 interrupt not routed");
  AST_LINE14_TIMER: assert property (
    mode_control_reg[14] && s14 == SEL_01
    |=> pin_oe[14] && pin_out[14] == $past(timer_p1_out0))
    else $error("line 14 timer output not driven");
  AST_LINE13_CLOCK: assert property (
    mode_control_reg[13] && s13 == SEL_11
    |=> pin_oe[13] && pin_out[13] == $past(prog_clock_out))
    else $error("line 13 clock output not driven");
  AST_LINE12_FORBID: assert property (
    mode_control_reg[12] && s12 == SEL_11 |=> !pin_oe[12])
    else $error("line 12 drives in a forbidden setting");
  AST_LINE9_DEBUG: assert property (
    mode_control_reg[9] && function_select_low[9]
    |=> func_in[FIN_DBG_MODE] == $past(pin_sync[9]) && !pin_oe[9])
    else $error("line 9 debug mode input not routed");
  AST_LINE8_SERIAL: assert property (
    mode_control_reg[8] && !function_select_low[8]
    |=> pin_oe[8] && pin_out[8] == $past(serial2_data_out))
    else $error("line 8 serial output not driven");
  AST_LINE3_SELECT: assert property (
    mode_control_reg[3] && s3 == SEL_00
    |=> pin_oe[3] && pin_out[3] == $past(csi_chip_select2))
    else $error("line 3 chip select not driven");
  AST_IDLE_IRQ4: assert property (
    !mode_control_reg[13] |=> !func_in[FIN_IRQ4])
    else $error("interrupt 4 input not idle");

endmodule
`default_nettype wire

// *** hdl/port9_mux_pkg.sv ***
// Constants shared by the port-9 pin-function multiplexer.
package port9_mux_pkg;

  localparam int LINES = 16;
  localparam int APB_W = 32;

  // Register indices; the bus address of each is four times its index.
  localparam logic [APB_W-1:0] PORT_DATA_IDX = 32'hFFFFF412;
  localparam logic [APB_W-1:0] DIRECTION_IDX = 32'hFFFFF432;
  localparam logic [APB_W-1:0] MODE_CTRL_IDX = 32'hFFFFF452;
  localparam logic [APB_W-1:0] FSEL_LOW_IDX = 32'hFFFFF472;
  localparam logic [APB_W-1:0] FSEL_HIGH_IDX = 32'hFFFFF712;

  localparam logic [APB_W-1:0] PORT_DATA_ADDR = {PORT_DATA_IDX[APB_W-3:0], 2'b00};
  localparam logic [APB_W-1:0] DIRECTION_ADDR = {DIRECTION_IDX[APB_W-3:0], 2'b00};
  localparam logic [APB_W-1:0] MODE_CTRL_ADDR = {MODE_CTRL_IDX[APB_W-3:0], 2'b00};
  localparam logic [APB_W-1:0] FSEL_LOW_ADDR = {FSEL_LOW_IDX[APB_W-3:0], 2'b00};
  localparam logic [APB_W-1:0] FSEL_HIGH_ADDR = {FSEL_HIGH_IDX[APB_W-3:0], 2'b00};

  localparam logic [LINES-1:0] PORT_DATA_RESET = 16'h0000;
  localparam logic [LINES-1:0] DIRECTION_RESET = 16'hFFFF;
  localparam logic [LINES-1:0] MODE_CTRL_RESET = 16'h0000;
  localparam logic [LINES-1:0] FSEL_RESET = 16'h0000;

  // Function pair {high bit, low bit} for one line.
  localparam logic [1:0] SEL_00 = 2'b00;
  localparam logic [1:0] SEL_01 = 2'b01;
  localparam logic [1:0] SEL_10 = 2'b10;
  localparam logic [1:0] SEL_11 = 2'b11;

  // Bit positions of the peripheral inputs fed by the multiplexer.
  localparam int FIN_CSI_CLK = 0;
  localparam int FIN_UART_RX = 1;
  localparam int FIN_UART_BAUD = 2;
  localparam int FIN_Q1_IN0 = 3;
  localparam int FIN_Q1_IN1 = 4;
  localparam int FIN_Q1_IN2 = 5;
  localparam int FIN_Q1_IN3 = 6;
  localparam int FIN_P1_IN0 = 7;
  localparam int FIN_P1_IN1 = 8;
  localparam int FIN_P2_IN0 = 9;
  localparam int FIN_P2_IN1 = 10;
  localparam int FIN_IRQ4 = 11;
  localparam int FIN_IRQ5 = 12;
  localparam int FIN_IRQ6 = 13;
  localparam int FIN_S2_DIN = 14;
  localparam int FIN_S2_CLK = 15;
  localparam int FIN_DBG_MODE = 16;
  localparam int FIN_DBG_CLK = 17;
  localparam int FIN_DBG_DATA = 18;
  localparam int FIN_ADDR_DATA_BIT14 = 19;
  localparam int FIN_ADDR_DATA_BIT15 = 20;
  localparam int FIN_W = 21;

  // Idle levels: all low, except the UART receive line which idles high.
  localparam logic [FIN_W-1:0] FIN_IDLE = 21'h000002;

endpackage

// *** tb/pin_world.sv ***
// External pin model for the port-9 lines: drives a pin only while the block releases it.
`timescale 1ns/100ps
`default_nettype none
module pin_world
  import port9_mux_pkg::*;
(
  input wire logic pclk,
  input wire logic [LINES-1:0] pin_out,
  input wire logic [LINES-1:0] pin_oe,
  input wire logic [LINES-1:0] ext_drv,
  input wire logic [LINES-1:0] ext_en,
  output logic [LINES-1:0] pin_in
);
  // A released, undriven pin floats; toggling it stops a stale level from passing a check.
  logic [LINES-1:0] float_q = 16'h0000;
  always @(posedge pclk)
  begin
    float_q <= ~float_q;
  end
  // The far side backs off while the block drives a line, so the two never fight.
  assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext_en & ext_drv)
                  | (~pin_oe & ~ext_en & float_q);
endmodule
`default_nettype wire

// *** tb/tb_top.sv ***
// Self-checking bench for the port-9 pin-function multiplexer and its registers.
`timescale 1ns/100ps
`default_nettype none
module tb_top
  import port9_mux_pkg::*;
;
  typedef struct packed {logic [3:0] line; logic [1:0] sel; logic [21:0] po;
    logic [20:0] fin;} row_s;
  // A source mask of all ones marks a row where the line must stay undriven.
  localparam logic [21:0] ALL = 22'h3FFFFF;
  row_s rows [0:43] = '{
    '{4'h0, 2'h0, 22'h000003, 21'h000001}, '{4'h0, 2'h1, 22'h000100, 21'h000000},
    '{4'h0, 2'h2, ALL, 21'h000010}, '{4'h0, 2'h3, ALL, 21'h000000},
    '{4'h1, 2'h0, 22'h000004, 21'h000000}, '{4'h1, 2'h1, 22'h000200, 21'h000000},
    '{4'h1, 2'h2, ALL, 21'h000020}, '{4'h1, 2'h3, ALL, 21'h000000},
    '{4'h2, 2'h0, 22'h000008, 21'h000000}, '{4'h2, 2'h1, 22'h000400, 21'h000000},
    '{4'h2, 2'h2, ALL, 21'h000040}, '{4'h2, 2'h3, ALL, 21'h000000},
    '{4'h3, 2'h0, 22'h000010, 21'h000000}, '{4'h3, 2'h1, 22'h000080, 21'h000000},
    '{4'h3, 2'h2, ALL, 21'h000008}, '{4'h3, 2'h3, ALL, 21'h000000},
    '{4'h4, 2'h0, 22'h000020, 21'h000000}, '{4'h4, 2'h1, ALL, 21'h000004},
    '{4'h5, 2'h0, 22'h000003, 21'h000003}, '{4'h5, 2'h1, ALL, 21'h000002},
    '{4'h6, 2'h0, 22'h000044, 21'h000000}, '{4'h6, 2'h1, 22'h000040, 21'h000000},
    '{4'h7, 2'h0, ALL, 21'h004000}, '{4'h7, 2'h1, ALL, 21'h040000},
    '{4'h8, 2'h0, 22'h010000, 21'h000000}, '{4'h8, 2'h1, ALL, 21'h020000},
    '{4'h9, 2'h0, 22'h060000, 21'h008000}, '{4'h9, 2'h1, ALL, 21'h010000},
    '{4'hC, 2'h0, 22'h000010, 21'h000000}, '{4'hC, 2'h1, 22'h004000, 21'h000000},
    '{4'hC, 2'h2, ALL, 21'h000400}, '{4'hC, 2'h3, ALL, 21'h000000},
    '{4'hD, 2'h0, ALL, 21'h000800}, '{4'hD, 2'h1, 22'h002000, 21'h000000},
    '{4'hD, 2'h2, ALL, 21'h000200}, '{4'hD, 2'h3, 22'h008000, 21'h000000},
    '{4'hE, 2'h0, ALL, 21'h001000}, '{4'hE, 2'h1, 22'h000800, 21'h000000},
    '{4'hE, 2'h2, ALL, 21'h000080}, '{4'hE, 2'h3, 22'h280000, 21'h080000},
    '{4'hF, 2'h0, ALL, 21'h002000}, '{4'hF, 2'h1, 22'h001000, 21'h000000},
    '{4'hF, 2'h2, ALL, 21'h000100}, '{4'hF, 2'h3, 22'h300000, 21'h100000}};
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err_q;
  logic [31:0] paddr, pwdata, prdata, rd_q, sel_a;
  logic [3:0] pstrb;
  logic [15:0] pin_in, pin_out, pin_oe, ext_drv, ext_en, e16;
  logic [21:0] po;
  logic [20:0] func_in;
  int n_fail = 0;
  int num_checks = 0;
  int v;
  port9_function_select port9_function_select_i (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
    .pready(pready), .prdata(prdata), .pslverr(pslverr), .pin_in(pin_in), .pin_out(pin_out),
    .pin_oe(pin_oe), .csi_ch_clock_out(po[0]), .csi_ch_clock_oe(po[1]),
    .csi_chip_select0(po[2]), .csi_chip_select1(po[3]), .csi_chip_select2(po[4]),
    .csi_chip_select3(po[5]), .uart1_transmit(po[6]), .timer_q1_out0(po[7]),
    .timer_q1_out1(po[8]), .timer_q1_out2(po[9]), .timer_q1_out3(po[10]),
    .timer_p1_out0(po[11]), .timer_p1_out1(po[12]), .timer_p2_out0(po[13]),
    .timer_p2_out1(po[14]), .prog_clock_out(po[15]), .serial2_data_out(po[16]),
    .serial2_clock_out(po[17]), .serial2_clock_oe(po[18]), .addr_data_bit14_out(po[19]),
    .addr_data_bit15_out(po[20]), .addr_data_oe(po[21]), .func_in(func_in));
  pin_world pin_world_i (.pclk(pclk), .pin_out(pin_out), .pin_oe(pin_oe), .ext_drv(ext_drv),
    .ext_en(ext_en), .pin_in(pin_in));
  initial
  begin
    pclk = 1'b0;
    forever #10 pclk = ~pclk;
  end
  task automatic complete_run();
    if (n_fail == 0 && num_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // One APB transfer; the request is held until pready is seen high at a rising edge.
  task automatic apb(input logic w, input logic [31:0] a, input logic [15:0] d,
                     input logic [3:0] s);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= {16'h0000, d};
    pstrb <= s;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge pclk);
      n++;
    end
    while (pready !== 1'b1 && n < 20);
    rd_q = prdata;
    err_q = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1)
    begin
      n_fail++;
      complete_run();
    end
  endtask
  initial
  begin
    {presetn, psel, penable, pwrite, paddr, pwdata, pstrb} = '0;
    {po, ext_drv, ext_en} = '0;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    chk(32'(func_in), 32'(FIN_IDLE));
    chk(32'(pin_oe), 32'h00000000);
    apb(1'b0, MODE_CTRL_ADDR, 16'h0000, 4'h0);
    chk(rd_q, 32'h00000000);
    apb(1'b0, DIRECTION_ADDR, 16'h0000, 4'h0);
    chk(rd_q, 32'h0000FFFF);
    apb(1'b0, FSEL_LOW_ADDR, 16'h0000, 4'h0);
    chk(rd_q, 32'h00000000);
    apb(1'b0, FSEL_HIGH_ADDR, 16'h0000, 4'h0);
    chk(rd_q, 32'h00000000);
    apb(1'b0, 32'h00000000, 16'h0000, 4'h0);
    chk({rd_q[30:0], err_q}, 32'h00000001);
    apb(1'b1, PORT_DATA_ADDR, 16'h8001, 4'h3);
    apb(1'b1, DIRECTION_ADDR, 16'h7FFE, 4'h3);
    @(posedge pclk);
    #1;
    chk({pin_oe, pin_out & pin_oe}, 32'h80018001);
    apb(1'b1, DIRECTION_ADDR, 16'hFFFF, 4'h3);
    for (int a = 0; a < 2; a++)
    begin
      sel_a = (a == 0) ? FSEL_LOW_ADDR : FSEL_HIGH_ADDR;
      apb(1'b1, sel_a, 16'hFFFF, 4'h1);
      apb(1'b0, sel_a, 16'h0000, 4'h0);
      chk(rd_q, 32'h000000FF);
      apb(1'b1, sel_a, 16'hA500, 4'h2);
      apb(1'b0, sel_a, 16'h0000, 4'h0);
      chk(rd_q, 32'h0000A5FF);
      apb(1'b1, sel_a, 16'h0000, 4'h0);
      apb(1'b0, sel_a, 16'h0000, 4'h0);
      chk(rd_q, 32'h0000A5FF);
      apb(1'b1, sel_a, 16'h0000, 4'h3);
    end
    for (int i = 0; i < 44; i++)
    begin
      apb(1'b1, MODE_CTRL_ADDR, 16'h0001 << rows[i].line, 4'h3);
      apb(1'b1, FSEL_LOW_ADDR, {15'h0000, rows[i].sel[0]} << rows[i].line, 4'h3);
      apb(1'b1, FSEL_HIGH_ADDR, {15'h0000, rows[i].sel[1]} << rows[i].line, 4'h3);
      @(posedge pclk);
      po <= rows[i].po;
      ext_en <= 16'h0000;
      repeat (2) @(posedge pclk);
      #1;
      e16 = (rows[i].po !== ALL) ? 16'h0001 << rows[i].line : 16'h0000;
      chk({pin_oe, pin_out & pin_oe}, {e16, e16});
      // Drive high first: a line that was driving high is then released without a glitch.
      for (v = 1; v >= 0; v--)
      begin
        @(posedge pclk);
        po <= '0;
        ext_en <= 16'h0001 << rows[i].line;
        ext_drv <= {16{v[0]}};
        repeat (3) @(posedge pclk);
        #1;
        chk(32'(func_in),
            32'((FIN_IDLE & ~rows[i].fin) | (v == 1 ? rows[i].fin : 21'h0)));
      end
    end
    apb(1'b1, FSEL_LOW_ADDR, 16'h00FF, 4'h3);
    @(posedge pclk);
    presetn <= 1'b0;
    @(posedge pclk);
    #1;
    chk({11'h000, func_in}, {11'h000, FIN_IDLE});
    chk(32'(pin_oe), 32'h00000000);
    @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, FSEL_LOW_ADDR, 16'h0000, 4'h0);
    chk(rd_q, 32'h00000000);
    complete_run();
  end
endmodule
`default_nettype wire
